// >>> shared/i2cf_pkg.sv
// Constants, carriers and state types for the two-wire FIFO controller
package i2cf_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FIFO = 8'h04;
  localparam logic [7:0] OFF_TXCTRL = 8'h08;
  localparam logic [7:0] OFF_RXCTRL = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_DMA = 8'h14;
  localparam logic [7:0] OFF_MCC = 8'h18;
  localparam logic [7:0] OFF_RXCNT = 8'h1c;
  localparam logic [7:0] OFF_LEVEL = 8'h20;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_MST = 1;
  localparam int unsigned CTRL_IRXM = 2;
  localparam int unsigned CTRL_ACK = 3;
  localparam int unsigned XC_FLUSH = 0;
  localparam int unsigned XC_PRELD = 1;
  localparam int unsigned XC_TH_LSB = 4;
  localparam int unsigned FL_TXLO = 0;
  localparam int unsigned FL_IRXM = 1;
  localparam int unsigned DMA_TX = 0;
  localparam int unsigned DMA_RX = 1;
  localparam int unsigned MC_START = 0;
  localparam int unsigned MC_RESTART = 1;
  localparam int unsigned MC_STOP = 2;
  localparam int unsigned LVL_RX_LSB = 8;
  localparam logic [7:0] EMPTY_BYTE = 8'hff;
  localparam logic [3:0] RXTH_RST = 4'h1;
  localparam logic [7:0] RXCNT_RST = 8'h01;
  // ----------------------------------------
  // Timing and bit counting
  // ----------------------------------------
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned T_SUDAT_NS = 250;
  localparam int unsigned SUDAT_CYC = (T_SUDAT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] ACK_FALL = 4'h9;
  // ----------------------------------------
  // Carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic arb_err;
    logic timeout;
    logic addr_nack;
    logic data_nack;
    logic start_err;
    logic stop_det;
    logic gc_match;
    logic sa_match;
    logic slv_tx_nack;
    logic bus_start;
  } i2cf_evt_t;
  typedef struct packed {
    logic start;
    logic restart;
    logic stop;
  } i2cf_cond_t;
  typedef enum logic [1:0] {IR_IDLE = 2'b00, IR_HOLD = 2'b01, IR_SETUP = 2'b11,
    IR_ACK = 2'b10} i2cf_irx_t;
  typedef enum logic [1:0] {MS_IDLE = 2'b00, MS_XFER = 2'b01, MS_STOP = 2'b11} i2cf_ms_t;
endpackage : i2cf_pkg

// >>> hdl/i2cf_ctrl.sv
// FIFO, interactive receive, DMA request and master condition control
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
// Function
// - Data write enqueues; dropped when full
// - Data read dequeues; empty gives 0xFF
// - Only low byte stored; upper read bits zero
// - Port disable flushes both; flush bits individually
// - Error or match events flush and lock transmit FIFO
// - Locked transmit FIFO ignores writes
// - Preload keeps FIFO on address matches
// - Hold clock and flag on 8th fall
// - Response bit selects ACK or NACK
// - Flag clear releases clock after setup time
// - Mode and count writable while flag pending
// - Interactive bytes bypass FIFO; unread gives 0xFF
// - Interactive handling for data bytes only
// - Transmit DMA when count at/below threshold
// - Receive DMA when count at/above threshold
// - START waits for free bus
// - RESTART after transaction; STOP cancels it
// - START cleared after STOP; STOP request honoured
// - START before RESTART; RESTART beats STOP
// - Master disable clears condition requests
module i2cf_ctrl
  import i2cf_pkg::*;
#(
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus engine side
  input wire i2cf_evt_t evt,
  input wire logic bus_busy,
  input wire logic data_phase,
  input wire logic xact_done,
  input wire logic stop_sent,
  input wire logic tx_pop,
  input wire logic rx_push,
  input wire logic [7:0] rx_byte,
  output logic [7:0] tx_byte,
  output logic tx_avail,
  output logic [7:0] rx_remain,
  output i2cf_cond_t cond_req,
  output logic port_enable,
  output logic master_en,
  // Two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  // DMA requests
  output logic tx_dma_req,
  output logic rx_dma_req
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  logic pready_reg, pslverr_reg, rd_pop_reg, rd_irx_reg, rd_stale_reg;
  logic [31:0] prdata_reg, rdata;
  logic wr, rd, mapped;
  assign wr = psel & penable & pready_reg & pwrite;
  assign rd = psel & penable & pready_reg & ~pwrite;
  assign mapped = hit(paddr, OFF_CTRL) | hit(paddr, OFF_FIFO) | hit(paddr, OFF_TXCTRL)
    | hit(paddr, OFF_RXCTRL) | hit(paddr, OFF_FLAGS) | hit(paddr, OFF_DMA)
    | hit(paddr, OFF_MCC) | hit(paddr, OFF_RXCNT) | hit(paddr, OFF_LEVEL);

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic en_reg, mst_reg, irxm_reg, ack_reg, preld_reg, txlo_reg, irxf_reg;
  logic dtx_reg, drx_reg, start_reg, restart_reg, stop_reg;
  logic [PW-1:0] txth_reg;
  logic [CW-1:0] rxth_reg;
  logic [7:0] rxcnt_reg;
  logic tx_flush_w, rx_flush_w, flags_w;
  assign tx_flush_w = wr & hit(paddr, OFF_TXCTRL) & pwdata[XC_FLUSH];
  assign rx_flush_w = wr & hit(paddr, OFF_RXCTRL) & pwdata[XC_FLUSH];
  assign flags_w = wr & hit(paddr, OFF_FLAGS);

  // Mode bits stay writable at any time, also while a byte is held
  always_ff @(posedge clk) begin
    if (rst) begin
      en_reg <= 1'b0;
      mst_reg <= 1'b0;
      irxm_reg <= 1'b0;
      ack_reg <= 1'b0;
      preld_reg <= 1'b0;
      txth_reg <= '0;
      rxth_reg <= CW'(RXTH_RST);
      dtx_reg <= 1'b0;
      drx_reg <= 1'b0;
      rxcnt_reg <= RXCNT_RST;
    end else if (wr) begin
      if (hit(paddr, OFF_CTRL)) begin
        en_reg <= pwdata[CTRL_EN];
        mst_reg <= pwdata[CTRL_MST];
        irxm_reg <= pwdata[CTRL_IRXM];
        ack_reg <= pwdata[CTRL_ACK];
      end
      if (hit(paddr, OFF_TXCTRL)) begin
        preld_reg <= pwdata[XC_PRELD];
        txth_reg <= pwdata[XC_TH_LSB +: PW];
      end
      if (hit(paddr, OFF_RXCTRL)) begin
        rxth_reg <= pwdata[XC_TH_LSB +: CW];
      end
      if (hit(paddr, OFF_DMA)) begin
        dtx_reg <= pwdata[DMA_TX];
        drx_reg <= pwdata[DMA_RX];
      end
      if (hit(paddr, OFF_RXCNT)) begin
        rxcnt_reg <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  logic [7:0] tx_mem [DEPTH];
  logic [PW-1:0] tx_wp, tx_rp;
  logic [CW-1:0] tx_cnt;
  logic tx_clr, tx_push, tx_take, lock_evt;
  // Stale data must not go out after an error or a fresh address match
  assign lock_evt = en_reg & ((evt.gc_match | evt.sa_match) & ~preld_reg
    | evt.slv_tx_nack | evt.arb_err | evt.timeout | evt.addr_nack
    | evt.data_nack | evt.start_err | evt.stop_det);
  assign tx_clr = ~en_reg | tx_flush_w | lock_evt;
  assign tx_push = wr & hit(paddr, OFF_FIFO) & (tx_cnt != CW'(DEPTH))
    & ~txlo_reg & ~tx_clr;
  assign tx_take = tx_pop & (tx_cnt != '0) & ~tx_clr;

  // Pointers wrap naturally, so DEPTH is a power of two
  always_ff @(posedge clk) begin
    if (rst || tx_clr) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      tx_wp <= tx_wp + PW'(tx_push);
      tx_rp <= tx_rp + PW'(tx_take);
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_take);
    end
  end

  // Only the low byte of a wide write is kept
  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= pwdata[7:0];
    end
  end

  // Lockout flag: a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      txlo_reg <= 1'b0;
    end else if (lock_evt) begin
      txlo_reg <= 1'b1;
    end else if (flags_w && pwdata[FL_TXLO]) begin
      txlo_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  logic [7:0] rx_mem [DEPTH];
  logic [PW-1:0] rx_wp, rx_rp;
  logic [CW-1:0] rx_cnt;
  logic rx_clr, rx_put, rx_take;
  assign rx_clr = ~en_reg | rx_flush_w;
  // Data bytes skip the FIFO in interactive mode; a full FIFO drops them
  assign rx_put = rx_push & ~(irxm_reg & data_phase) & (rx_cnt != CW'(DEPTH)) & ~rx_clr;
  assign rx_take = rd & hit(paddr, OFF_FIFO) & rd_pop_reg & ~rx_clr;

  always_ff @(posedge clk) begin
    if (rst || rx_clr) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      rx_wp <= rx_wp + PW'(rx_put);
      rx_rp <= rx_rp + PW'(rx_take);
      rx_cnt <= rx_cnt + CW'(rx_put) - CW'(rx_take);
    end
  end

  always_ff @(posedge clk) begin
    if (rx_put) begin
      rx_mem[rx_wp] <= rx_byte;
    end
  end

  // ----------------------------------------
  // Pin sampling and bit counting
  // ----------------------------------------
  logic [1:0] pin_s1, pin_s2;
  logic scl_prev, scl_fall, scl_rise;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
      scl_prev <= 1'b1;
    end else begin
      pin_s1 <= {sda_i, scl_i};
      pin_s2 <= pin_s1;
      scl_prev <= pin_s2[0];
    end
  end
  assign scl_fall = scl_prev & ~pin_s2[0];
  assign scl_rise = ~scl_prev & pin_s2[0];

  // The fall right after a START is no bit, hence the preset to the ack slot
  always_ff @(posedge clk) begin
    if (rst || !en_reg || evt.bus_start || evt.stop_det) begin
      bit_cnt <= BIT_LAST;
    end else if (scl_fall) begin
      // The ack fall wraps to zero so the next byte's first rise shifts
      bit_cnt <= (bit_cnt == BIT_LAST) ? '0 : bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shreg <= '0;
    end else if (scl_rise && bit_cnt < BIT_LAST) begin
      shreg <= {shreg[6:0], pin_s2[1]};
    end
  end

  // ----------------------------------------
  // Interactive receive
  // ----------------------------------------
  i2cf_irx_t irx_st;
  logic [3:0] su_cnt;
  logic irx_trig, irx_valid, stale_reg, scl_oe_reg, sda_oe_reg;
  logic [7:0] irx_byte;
  // Address, general call and START bytes are not data_phase
  assign irx_trig = scl_fall & (bit_cnt == BIT_LAST - 4'h1) & irxm_reg
    & data_phase & (irx_st == IR_IDLE);

  always_ff @(posedge clk) begin
    if (rst || !en_reg) begin
      irx_st <= IR_IDLE;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      su_cnt <= '0;
    end else begin
      case (irx_st)
        IR_IDLE: if (irx_trig) begin
          irx_st <= IR_HOLD;
          scl_oe_reg <= 1'b1;
        end
        IR_HOLD: if (!irxf_reg) begin
          irx_st <= IR_SETUP;
          sda_oe_reg <= ~ack_reg;
          su_cnt <= '0;
        end
        IR_SETUP: begin
          su_cnt <= su_cnt + 4'h1;
          // Release only once the data setup time has run out
          if (su_cnt == 4'(SUDAT_CYC - 1)) begin
            scl_oe_reg <= 1'b0;
            irx_st <= IR_ACK;
          end
        end
        IR_ACK: if (scl_fall) begin
          sda_oe_reg <= 1'b0;
          irx_st <= IR_IDLE;
        end
        default: irx_st <= IR_IDLE;
      endcase
    end
  end

  // Held flag: set wins over the write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irxf_reg <= 1'b0;
    end else if (irx_trig) begin
      irxf_reg <= 1'b1;
    end else if (flags_w && pwdata[FL_IRXM]) begin
      irxf_reg <= 1'b0;
    end
  end

  // Leaving the mode with an unread byte poisons the next data read
  always_ff @(posedge clk) begin
    if (rst || !en_reg) begin
      irx_valid <= 1'b0;
      stale_reg <= 1'b0;
      irx_byte <= '0;
    end else if (irx_trig) begin
      irx_valid <= 1'b1;
      irx_byte <= shreg;
    end else if (irx_valid && !irxm_reg) begin
      irx_valid <= 1'b0;
      stale_reg <= 1'b1;
    end else if (rd && hit(paddr, OFF_FIFO)) begin
      if (rd_irx_reg) begin
        irx_valid <= 1'b0;
      end
      if (rd_stale_reg) begin
        stale_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Master condition control
  // ----------------------------------------
  i2cf_ms_t ms_st;
  i2cf_cond_t cond_reg;
  always_ff @(posedge clk) begin
    if (rst || !mst_reg) begin
      start_reg <= 1'b0;
      restart_reg <= 1'b0;
      stop_reg <= 1'b0;
      ms_st <= MS_IDLE;
      cond_reg <= '0;
    end else begin
      cond_reg <= '0;
      if (wr && hit(paddr, OFF_MCC)) begin
        start_reg <= pwdata[MC_START];
        restart_reg <= pwdata[MC_RESTART];
        stop_reg <= pwdata[MC_STOP];
      end
      if (evt.stop_det) begin
        restart_reg <= 1'b0;
      end
      case (ms_st)
        MS_IDLE: if (start_reg && !bus_busy) begin
          cond_reg.start <= 1'b1;
          ms_st <= MS_XFER;
        end else if (stop_reg && !start_reg) begin
          cond_reg.stop <= 1'b1;
          stop_reg <= 1'b0;
        end
        MS_XFER: if (xact_done && restart_reg) begin
          cond_reg.restart <= 1'b1;
          restart_reg <= 1'b0;
          stop_reg <= 1'b0;
        end else if (xact_done || (stop_reg && !restart_reg)) begin
          cond_reg.stop <= 1'b1;
          stop_reg <= 1'b0;
          ms_st <= MS_STOP;
        end
        MS_STOP: if (stop_sent) begin
          start_reg <= 1'b0;
          ms_st <= MS_IDLE;
        end
        default: ms_st <= MS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Read data and APB answer
  // ----------------------------------------
  always_comb begin
    rdata = '0;
    if (hit(paddr, OFF_CTRL)) begin
      rdata[CTRL_EN] = en_reg;
      rdata[CTRL_MST] = mst_reg;
      rdata[CTRL_IRXM] = irxm_reg;
      rdata[CTRL_ACK] = ack_reg;
    end else if (hit(paddr, OFF_FIFO)) begin
      if (irxm_reg && irx_valid) begin
        rdata[7:0] = irx_byte;
      end else if (stale_reg || rx_cnt == '0) begin
        rdata[7:0] = EMPTY_BYTE;
      end else begin
        rdata[7:0] = rx_mem[rx_rp];
      end
    end else if (hit(paddr, OFF_TXCTRL)) begin
      rdata[XC_PRELD] = preld_reg;
      rdata[XC_TH_LSB +: PW] = txth_reg;
    end else if (hit(paddr, OFF_RXCTRL)) begin
      rdata[XC_TH_LSB +: CW] = rxth_reg;
    end else if (hit(paddr, OFF_FLAGS)) begin
      rdata[FL_TXLO] = txlo_reg;
      rdata[FL_IRXM] = irxf_reg;
    end else if (hit(paddr, OFF_DMA)) begin
      rdata[DMA_TX] = dtx_reg;
      rdata[DMA_RX] = drx_reg;
    end else if (hit(paddr, OFF_MCC)) begin
      rdata[MC_START] = start_reg;
      rdata[MC_RESTART] = restart_reg;
      rdata[MC_STOP] = stop_reg;
    end else if (hit(paddr, OFF_RXCNT)) begin
      rdata[7:0] = rxcnt_reg;
    end else if (hit(paddr, OFF_LEVEL)) begin
      rdata[CW-1:0] = tx_cnt;
      rdata[LVL_RX_LSB +: CW] = rx_cnt;
    end
  end

  // Data is captured in setup so the access edge pops exactly what was shown
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      rd_pop_reg <= 1'b0;
      rd_irx_reg <= 1'b0;
      rd_stale_reg <= 1'b0;
    end else begin
      pready_reg <= psel & ~penable;
      if (psel && !penable) begin
        pslverr_reg <= ~mapped;
        prdata_reg <= pwrite ? '0 : rdata;
        rd_irx_reg <= irxm_reg & irx_valid;
        rd_stale_reg <= ~(irxm_reg & irx_valid) & stale_reg;
        rd_pop_reg <= ~(irxm_reg & irx_valid) & ~stale_reg & (rx_cnt != '0);
      end
    end
  end

  // ----------------------------------------
  // Engine and DMA outputs
  // ----------------------------------------
  logic [7:0] tx_byte_reg;
  logic tx_avail_reg, tdma_reg, rdma_reg, pin_lo_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_byte_reg <= '0;
      tx_avail_reg <= 1'b0;
      tdma_reg <= 1'b0;
      rdma_reg <= 1'b0;
      pin_lo_reg <= 1'b0;
    end else begin
      tx_byte_reg <= tx_mem[tx_rp];
      tx_avail_reg <= (tx_cnt != '0) & ~tx_clr;
      tdma_reg <= dtx_reg & (tx_cnt <= CW'(txth_reg));
      rdma_reg <= drx_reg & (rx_cnt >= rxth_reg);
      pin_lo_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_byte = tx_byte_reg;
  assign tx_avail = tx_avail_reg;
  assign rx_remain = rxcnt_reg;
  assign cond_req = cond_reg;
  assign port_enable = en_reg;
  assign master_en = mst_reg;
  assign scl_o = pin_lo_reg;
  assign sda_o = pin_lo_reg;
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign tx_dma_req = tdma_reg;
  assign rx_dma_req = rdma_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tx_full_drop: assert property (tx_cnt == CW'(DEPTH) && !tx_take |=> tx_cnt <= CW'(DEPTH))
    else $error("transmit FIFO grew past full");
  a_rx_empty_ff: assert property (rd && hit(paddr, OFF_FIFO) && !$past(irxm_reg)
    && $past(rx_cnt) == '0 |-> prdata[7:0] == EMPTY_BYTE)
    else $error("empty read did not return all ones");
  a_upper_zero: assert property (pready && hit(paddr, OFF_FIFO) |-> prdata[31:8] == '0)
    else $error("upper data bits not zero");
  a_off_flush: assert property (!en_reg |=> tx_cnt == '0 && rx_cnt == '0)
    else $error("disable did not flush");
  a_lock_set: assert property (lock_evt |=> txlo_reg && tx_cnt == '0)
    else $error("lock event not applied");
  a_lock_hold: assert property (txlo_reg && !lock_evt |=> tx_cnt <= $past(tx_cnt))
    else $error("locked FIFO accepted a byte");
  a_preload_keep: assert property (preld_reg && en_reg && !txlo_reg && evt.sa_match
    && !(evt.slv_tx_nack || evt.arb_err || evt.timeout || evt.addr_nack || evt.data_nack
    || evt.start_err || evt.stop_det) |=> !txlo_reg)
    else $error("preload match locked FIFO");
  a_hold_flag: assert property (irx_trig |=> (scl_oe && irxf_reg) [*2])
    else $error("held byte not flagged");
  a_ack_drive: assert property (irx_st == IR_SETUP |-> sda_oe == ~ack_reg)
    else $error("wrong acknowledge driven");
  a_setup_wait: assert property ($rose(irx_st == IR_SETUP) |-> scl_oe [*6])
    else $error("clock released early");
  a_tx_dma: assert property (dtx_reg && tx_cnt <= CW'(txth_reg) && $stable(dtx_reg)
    |=> tx_dma_req)
    else $error("transmit DMA missing");
  a_rx_dma: assert property (drx_reg && rx_cnt >= rxth_reg |=> rx_dma_req)
    else $error("receive DMA missing");
  a_restart_clr: assert property (cond_reg.restart |-> !restart_reg && !stop_reg)
    else $error("restart left bits set");
  a_mst_off: assert property (!mst_reg |=> !start_reg && !restart_reg && !stop_reg)
    else $error("condition bits survive disable");

  c_lockout: cover property (lock_evt ##1 txlo_reg);
  c_irx_cycle: cover property (irx_st == IR_HOLD ##[1:200] irx_st == IR_ACK);
  c_restart: cover property (cond_reg.start ##[1:500] cond_reg.restart);
endmodule : i2cf_ctrl

// >>> verif/i2cf_bus_model.sv
// Far-side model: engine strobes and open-drain bus pins
`timescale 1ns/100ps
module i2cf_bus_model
  import i2cf_pkg::*;
(
  // Clock and pin enables
  input wire logic clk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Pin levels
  output logic scl_i,
  output logic sda_i,
  // Engine side
  output i2cf_evt_t evt,
  output logic bus_busy,
  output logic data_phase,
  output logic xact_done,
  output logic stop_sent,
  output logic tx_pop,
  output logic rx_push,
  output logic [7:0] rx_byte
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  // Pull-ups keep lines high unless a party pulls low
  assign scl_i = scl_m & ~scl_oe;
  assign sda_i = sda_m & ~sda_oe;
  // Idle strobes at time zero
  initial begin
    {evt, bus_busy, data_phase, xact_done, stop_sent, tx_pop, rx_push} = '0;
    rx_byte = 8'h00;
  end
  // One-cycle event pulse
  task automatic ev(input i2cf_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask : ev
  // One-cycle engine strobe: {tx_pop, stop_sent, xact_done}
  task automatic strobe(input logic [2:0] s);
    @(posedge clk);
    {tx_pop, stop_sent, xact_done} <= s;
    @(posedge clk);
    {tx_pop, stop_sent, xact_done} <= 3'h0;
  endtask : strobe
  // Bus busy level
  task automatic busy(input logic b);
    bus_busy <= b;
  endtask : busy
  // Received byte; data inverted after release so stale values never match
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    rx_push <= 1'b1;
    rx_byte <= b;
    @(posedge clk);
    rx_push <= 1'b0;
    rx_byte <= ~b;
  endtask : push
  // Start fall, eight 320 ns bit periods MSB first, then the 8th data fall
  task automatic frame(input logic [7:0] b);
    bus_busy <= 1'b1;
    data_phase <= 1'b1;
    for (int k = 7; k >= 0; k--) begin
      repeat (4) @(posedge clk);
      scl_m <= 1'b0;
      sda_m <= b[k];
      repeat (4) @(posedge clk);
      scl_m <= 1'b1;
    end
    repeat (4) @(posedge clk);
    scl_m <= 1'b0;
    sda_m <= 1'b1;
  endtask : frame
  // Ack clock after release, then the bus goes idle
  task automatic ack_clk;
    repeat (4) @(posedge clk);
    scl_m <= 1'b1;
    repeat (4) @(posedge clk);
    scl_m <= 1'b0;
    repeat (4) @(posedge clk);
    scl_m <= 1'b1;
    {bus_busy, data_phase} <= 2'h0;
  endtask : ack_clk
endmodule : i2cf_bus_model

// >>> verif/i2cf_ctrl_tb_top.sv
// Self-checking bench for the two-wire FIFO controller
`timescale 1ns/100ps
`define CHK(a, e) chk(32'(a), 32'(e))
module i2cf_ctrl_tb_top;
  import i2cf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_v;
  logic pready, pslverr, err_v, scl_i, sda_i, scl_oe, sda_oe, scl_o, sda_o;
  logic bus_busy, data_phase, xact_done, stop_sent, tx_pop, rx_push;
  logic tx_dma_req, rx_dma_req, tx_avail, port_enable, master_en;
  logic [7:0] rx_byte, tx_byte, rx_remain;
  i2cf_evt_t evt;
  i2cf_cond_t cond_req, acc;
  int miscompares = 0;
  int comparisons = 0;
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  i2cf_ctrl u_i2cf_ctrl (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .bus_busy(bus_busy), .data_phase(data_phase),
    .xact_done(xact_done), .stop_sent(stop_sent), .tx_pop(tx_pop), .rx_push(rx_push),
    .rx_byte(rx_byte), .tx_byte(tx_byte), .tx_avail(tx_avail), .rx_remain(rx_remain),
    .cond_req(cond_req), .port_enable(port_enable), .master_en(master_en), .scl_i(scl_i),
    .sda_i(sda_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  i2cf_bus_model u_i2cf_bus_model (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl_i(scl_i), .sda_i(sda_i), .evt(evt), .bus_busy(bus_busy), .data_phase(data_phase),
    .xact_done(xact_done), .stop_sent(stop_sent), .tx_pop(tx_pop), .rx_push(rx_push),
    .rx_byte(rx_byte));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    comparisons++;
    if (a !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // OR of condition pulses over a span
  task automatic watch(input int n);
    acc = '0;
    repeat (n) begin
      @(posedge clk);
      acc = acc | cond_req;
    end
  endtask : watch
  // FIFO port: empty read, low byte only, full drop, receive depth
  task automatic t_fifo;
    rd(OFF_FIFO);
    `CHK(rd_v, 32'h0000_00ff);
    for (int i = 0; i < 9; i++) begin
      wr(OFF_FIFO, 32'hdead_bea0 + 32'(i));
    end
    `CHK(tx_byte, 8'ha0);
    rd(OFF_LEVEL);
    `CHK(rd_v[3:0], 4'h8);
    u_i2cf_bus_model.strobe(3'h4);
    rd(OFF_LEVEL);
    `CHK({tx_avail, tx_byte, rd_v[3:0]}, 13'h1a17);
    for (int i = 0; i < 9; i++) begin
      u_i2cf_bus_model.push(8'h30 + 8'(i));
    end
    rd(OFF_LEVEL);
    `CHK(rd_v[11:8], 4'h8);
    rd(OFF_FIFO);
    `CHK(rd_v, 32'h0000_0030);
    rd(8'h3c);
    `CHK(err_v, 1'h1);
  endtask : t_fifo
  // Flushes, every lock event, preload, port disable
  task automatic t_lock;
    wr(OFF_TXCTRL, 32'h1);
    rd(OFF_LEVEL);
    `CHK(rd_v[11:0], 12'h700);
    wr(OFF_RXCTRL, 32'h11);
    rd(OFF_LEVEL);
    `CHK(rd_v[11:0], 12'h000);
    for (int i = 1; i < 10; i++) begin
      wr(OFF_FIFO, 32'h11);
      u_i2cf_bus_model.ev(i2cf_evt_t'(10'h1 << i));
      wr(OFF_FIFO, 32'h22);
      rd(OFF_LEVEL);
      `CHK(rd_v[3:0], 4'h0);
      rd(OFF_FLAGS);
      `CHK(rd_v[0], 1'h1);
      wr(OFF_FLAGS, 32'h1);
    end
    wr(OFF_TXCTRL, 32'h2);
    wr(OFF_FIFO, 32'h33);
    u_i2cf_bus_model.ev(i2cf_evt_t'(10'h00c));
    u_i2cf_bus_model.push(8'h44);
    rd(OFF_LEVEL);
    `CHK(rd_v[11:0], 12'h101);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_LEVEL);
    `CHK(rd_v[11:0], 12'h000);
  endtask : t_lock
  // DMA requests across both threshold boundaries
  task automatic t_dma;
    wr(OFF_CTRL, 32'h1);
    wr(OFF_TXCTRL, 32'h30);
    wr(OFF_RXCTRL, 32'h20);
    wr(OFF_DMA, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_FIFO, 32'(i));
      u_i2cf_bus_model.push(8'(i));
      repeat (2) @(posedge clk);
      `CHK({tx_dma_req, rx_dma_req}, {i < 3, i > 0});
    end
  endtask : t_dma
  // START waits for free bus, RESTART beats STOP, master disable clears
  task automatic t_mcc;
    wr(OFF_CTRL, 32'h3);
    u_i2cf_bus_model.busy(1'b1);
    wr(OFF_MCC, 32'h7);
    watch(8);
    `CHK(acc, 3'h0);
    u_i2cf_bus_model.busy(1'b0);
    watch(8);
    `CHK(acc, 3'h4);
    u_i2cf_bus_model.strobe(3'h1);
    watch(8);
    `CHK(acc, 3'h2);
    rd(OFF_MCC);
    `CHK(rd_v[2:0], 3'h1);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_MCC);
    `CHK({master_en, rd_v[2:0]}, 4'h0);
    wr(OFF_CTRL, 32'h3);
    wr(OFF_MCC, 32'h4);
    watch(8);
    `CHK(acc, 3'h1);
    wr(OFF_MCC, 32'h1);
    u_i2cf_bus_model.strobe(3'h1);
    watch(8);
    `CHK(acc, 3'h1);
    u_i2cf_bus_model.strobe(3'h2);
    rd(OFF_MCC);
    `CHK(rd_v[2:0], 3'h0);
  endtask : t_mcc
  // Interactive receive: hold, flag, bypass read, ACK after setup time
  task automatic t_irxm;
    int n;
    wr(OFF_CTRL, 32'h5);
    u_i2cf_bus_model.frame(8'h5c);
    u_i2cf_bus_model.push(8'h5c);
    repeat (4) @(posedge clk);
    `CHK({scl_o, scl_oe}, 2'h1);
    wr(OFF_RXCNT, 32'h5);
    rd(OFF_FLAGS);
    `CHK(rd_v[1], 1'h1);
    `CHK({port_enable, rx_remain}, 9'h105);
    rd(OFF_FIFO);
    `CHK(rd_v, 32'h0000_005c);
    wr(OFF_FLAGS, 32'h2);
    n = 0;
    while (scl_oe === 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= SUDAT_CYC, 1'h1);
    `CHK(scl_oe, 1'h0);
    `CHK({sda_o, sda_oe}, 2'h1);
    u_i2cf_bus_model.ack_clk();
    `CHK(sda_oe, 1'h0);
  endtask : t_irxm
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(OFF_CTRL, 32'h1);
    t_fifo;
    t_lock;
    t_dma;
    t_mcc;
    t_irxm;
    close_out;
  end
  // Watchdog well past the expected run
  initial begin
    #1_000_000;
    miscompares++;
    close_out;
  end
endmodule : i2cf_ctrl_tb_top
